// file: pkg/rfi_regs.vh
// register indices, field layouts, reset values and timing for the regulator fault irq block
`ifndef RFI_REGS_VH
`define RFI_REGS_VH

// register indices; byte address is four times the index
`define RFI_IDX_HS_STAT 6'h0B
`define RFI_IDX_HS_MASK 6'h0C
`define RFI_IDX_HS_SENSE 6'h0D
`define RFI_IDX_DVS_STAT 6'h0E
`define RFI_IDX_DVS_MASK 6'h0F
`define RFI_IDX_DVS_SENSE 6'h10
`define RFI_IDX_LIN_STAT 6'h18
`define RFI_IDX_LIN_MASK 6'h19
`define RFI_IDX_LIN_SENSE 6'h1A

// field widths: three bucks, two scaling bucks, three linear regulators
`define RFI_HS_W 3
`define RFI_DVS_W 2
`define RFI_LIN_W 3

// bit positions
`define RFI_BIT_BUCK1 0
`define RFI_BIT_BUCK2 1
`define RFI_BIT_BUCK3 2

// reset values
`define RFI_STAT_RST 8'h00
`define RFI_SENSE_RST 8'h00
`define RFI_HS_MASK_RST 3'h7
`define RFI_DVS_MASK_RST 2'h3
`define RFI_LIN_MASK_RST 3'h7

// timing
`define RFI_CLK_PERIOD_NS 4
`define RFI_BUCK_SW_PERIOD_NS 500

`endif

// file: hdl/rfi_regulator_fault_irq_regs.v
// regulator fault interrupt status, mask and sense registers on a wishbone slave
//
// Function
// - mask bit 0 lets a set status bit pull the interrupt pin low
// - mask bit 1 keeps a set status bit off the interrupt pin
// - buck three high-side mask at bit 2, resets to 1, bits 7-3 unused
// - high-side sense bits 0-2 read-only, reset 0, show fault seen in the last window
// - high-side sense holds steady per switching cycle, reporting faults seen in it
// - scaling-done flag set on every voltage change of buck one or two
// - status bit clears on read or on writing one; writing zero keeps it
// - scaling-done masks at bits 0-1, read-write, reset 1, bits 7-2 unused
// - scaling sense bits 0-1 read 1 while scaling runs, reset 0
// - linear regulator limit flags at bits 0-2, reset 0, set on limit event
// - status 1 means event seen and not cleared, 0 cleared or never
// - scaling-done 0 means not done or cleared, 1 means done
//
// register map, word index on adr[7:2], data in the low byte
//    0x0B  high-side limit status, read or write one to clear
//    0x0C  high-side limit mask, read-write, resets all masked
//    0x0D  high-side limit sense, read-only, windowed per switching cycle
//    0x0E  scaling-done status, read or write one to clear
//    0x0F  scaling-done mask, read-write, resets all masked
//    0x10  scaling busy sense, read-only, synced busy level
//    0x18  linear limit status, read or write one to clear
//    0x19  linear limit mask, read-write, resets all masked
//    0x1A  linear limit sense, read-only, synced fault level
//    other indices read zero, writes dropped, always acked
//
// bus timing
//    request taken on the edge where cyc and stb are high and ack is low
//    ack follows one cycle later and lasts one cycle
//    read data registered with the ack, held until the next read
//    read-to-clear and write-one-to-clear act on the taking edge
//    a write with sel[0] low is acked but changes nothing
//    stb still high in the ack cycle is not taken a second time
//
// event capture
//    every detector level passes two flops before any logic reads it
//    high-side faults chop at the switching rate, so they are gathered
//    over one window of SW_PERIOD_CYC cycles and published at its end
//    a high-side event is a window sense going from clear to fault
//    a scaling-done event is the synced busy level falling
//    a linear limit event is the synced fault level rising
//    a fault that persists sets its status once, not every cycle
//    an event in the same cycle as a clear of its bit wins
//
// interrupt
//    irq_o is a registered level, one cycle behind the pending term
//    pending is any status bit with its mask bit clear
//    the pin is open-drain: value fixed low, enable high while pending
//    a host that only clears by reading must read every status word
//
// hazards and limits
//    window length is a parameter; a mismatch with the real switching
//    period makes the sense bit beat against the chopping fault
//    the counter is sixteen bits, so windows above 65536 cycles wrap
//    synchroniser latency delays every event by two to three cycles
//    read-to-clear clears the whole word, pending bits included, so a
//    debugger read loses interrupts just as a driver read would
//    masks only gate the pin, status bits latch whatever the mask
//
// reset
//    synchronous, active low; one edge is enough, two are safer
//    all status and sense bits clear, all masks set, pin released
`timescale 1ns/1ns
`default_nettype none
`include "rfi_regs.vh"

module rfi_regulator_fault_irq_regs #(
   parameter SW_PERIOD_CYC =
      (`RFI_BUCK_SW_PERIOD_NS + `RFI_CLK_PERIOD_NS - 1) / `RFI_CLK_PERIOD_NS
) (
   input wire mclk,
   input wire rst_b,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire [2:0] buck_hs_fault_in,
   input wire [1:0] buck_scaling_busy_in,
   input wire [2:0] linear_fault_in,
   output wire irq_o,
   output wire irq_out_n,
   output wire irq_out_n_oe
);

   localparam HS_W = `RFI_HS_W;
   localparam DVS_W = `RFI_DVS_W;
   localparam LIN_W = `RFI_LIN_W;
   localparam RAW_W = HS_W + DVS_W + LIN_W;
   localparam CNT_W = 16;
   localparam integer SW_LAST_I = SW_PERIOD_CYC - 1;
   localparam [CNT_W-1:0] SW_LAST = SW_LAST_I[CNT_W-1:0];

   // synchroniser stages for the analog detector levels
   reg [RAW_W-1:0] meta_reg;
   reg [RAW_W-1:0] sync_reg;
   wire [HS_W-1:0] hs_live;
   wire [DVS_W-1:0] dvs_live;
   wire [LIN_W-1:0] lin_live;

   // switching cycle window
   reg [CNT_W-1:0] sw_cnt_reg;
   reg [CNT_W-1:0] sw_cnt_next;
   wire sw_tick;
   reg [HS_W-1:0] hs_seen_reg;
   reg [HS_W-1:0] hs_seen_next;
   reg [HS_W-1:0] hs_sense_reg;
   reg [HS_W-1:0] hs_sense_next;

   // live sense of scaling and linear faults
   reg [DVS_W-1:0] dvs_sense_reg;
   reg [LIN_W-1:0] lin_sense_reg;

   // events, one cycle each
   wire [HS_W-1:0] hs_evt;
   wire [DVS_W-1:0] dvs_evt;
   wire [LIN_W-1:0] lin_evt;

   // status and mask registers
   reg [HS_W-1:0] hs_stat_reg;
   reg [HS_W-1:0] hs_stat_next;
   reg [HS_W-1:0] hs_mask_reg;
   reg [HS_W-1:0] hs_mask_next;
   reg [DVS_W-1:0] dvs_stat_reg;
   reg [DVS_W-1:0] dvs_stat_next;
   reg [DVS_W-1:0] dvs_mask_reg;
   reg [DVS_W-1:0] dvs_mask_next;
   reg [LIN_W-1:0] lin_stat_reg;
   reg [LIN_W-1:0] lin_stat_next;
   reg [LIN_W-1:0] lin_mask_reg;
   reg [LIN_W-1:0] lin_mask_next;

   // bus side
   reg ack_reg;
   reg [31:0] dat_reg;
   reg [7:0] rd_byte;
   wire req;
   wire wr_en;
   wire rd_en;
   wire [5:0] idx;
   wire [7:0] wbyte;

   // interrupt pin
   reg irq_reg;
   wire irq_pend;

   // two flops on every detector input before any use
   always @(posedge mclk) begin
      if (!rst_b) begin
         meta_reg <= {RAW_W{1'b0}};
         sync_reg <= {RAW_W{1'b0}};
      end else begin
         meta_reg <= {linear_fault_in, buck_scaling_busy_in, buck_hs_fault_in};
         sync_reg <= meta_reg;
      end
   end

   assign hs_live = sync_reg[HS_W-1:0];
   assign dvs_live = sync_reg[HS_W+DVS_W-1:HS_W];
   assign lin_live = sync_reg[RAW_W-1:HS_W+DVS_W];

   // divider marking the end of each switching cycle
   assign sw_tick = (sw_cnt_reg == SW_LAST);

   always @* begin
      if (sw_tick) begin
         sw_cnt_next = {CNT_W{1'b0}};
      end else begin
         sw_cnt_next = sw_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // gather faults over the cycle, publish once per cycle
   always @* begin
      hs_sense_next = hs_sense_reg;
      if (sw_tick) begin
         hs_seen_next = {HS_W{1'b0}};
         hs_sense_next = hs_seen_reg | hs_live;
      end else begin
         hs_seen_next = hs_seen_reg | hs_live;
      end
   end

   always @(posedge mclk) begin
      if (!rst_b) begin
         sw_cnt_reg <= {CNT_W{1'b0}};
         hs_seen_reg <= {HS_W{1'b0}};
         hs_sense_reg <= {HS_W{1'b0}};
      end else begin
         sw_cnt_reg <= sw_cnt_next;
         hs_seen_reg <= hs_seen_next;
         hs_sense_reg <= hs_sense_next;
      end
   end

   // scaling busy and linear fault sense follow the synced level
   always @(posedge mclk) begin
      if (!rst_b) begin
         dvs_sense_reg <= {DVS_W{1'b0}};
         lin_sense_reg <= {LIN_W{1'b0}};
      end else begin
         dvs_sense_reg <= dvs_live;
         lin_sense_reg <= lin_live;
      end
   end

   // high-side event: sense goes from clear to fault at a cycle end
   assign hs_evt = {HS_W{sw_tick}} & hs_sense_next & ~hs_sense_reg;
   // scaling done: busy falls, so each voltage change ends in one event
   assign dvs_evt = dvs_sense_reg & ~dvs_live;
   // linear limit: fault level rises
   assign lin_evt = lin_live & ~lin_sense_reg;

   // bus decode; one access taken per request, answered next cycle
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_en = req & wb_we_i & wb_sel_i[0];
   assign rd_en = req & ~wb_we_i;
   assign idx = wb_adr_i[7:2];
   assign wbyte = wb_dat_i[7:0];

   // high-side status: set wins over clear
   always @* begin
      hs_stat_next = hs_stat_reg;
      if (rd_en && idx == `RFI_IDX_HS_STAT) begin
         hs_stat_next = {HS_W{1'b0}};
      end else if (wr_en && idx == `RFI_IDX_HS_STAT) begin
         hs_stat_next = hs_stat_reg & ~wbyte[HS_W-1:0];
      end
      hs_stat_next = hs_stat_next | hs_evt;
   end

   // scaling-done status: set wins over clear
   always @* begin
      dvs_stat_next = dvs_stat_reg;
      if (rd_en && idx == `RFI_IDX_DVS_STAT) begin
         dvs_stat_next = {DVS_W{1'b0}};
      end else if (wr_en && idx == `RFI_IDX_DVS_STAT) begin
         dvs_stat_next = dvs_stat_reg & ~wbyte[DVS_W-1:0];
      end
      dvs_stat_next = dvs_stat_next | dvs_evt;
   end

   // linear limit status: set wins over clear
   always @* begin
      lin_stat_next = lin_stat_reg;
      if (rd_en && idx == `RFI_IDX_LIN_STAT) begin
         lin_stat_next = {LIN_W{1'b0}};
      end else if (wr_en && idx == `RFI_IDX_LIN_STAT) begin
         lin_stat_next = lin_stat_reg & ~wbyte[LIN_W-1:0];
      end
      lin_stat_next = lin_stat_next | lin_evt;
   end

   // mask writes
   always @* begin
      hs_mask_next = hs_mask_reg;
      dvs_mask_next = dvs_mask_reg;
      lin_mask_next = lin_mask_reg;
      if (wr_en && idx == `RFI_IDX_HS_MASK) begin
         hs_mask_next = wbyte[HS_W-1:0];
      end
      if (wr_en && idx == `RFI_IDX_DVS_MASK) begin
         dvs_mask_next = wbyte[DVS_W-1:0];
      end
      if (wr_en && idx == `RFI_IDX_LIN_MASK) begin
         lin_mask_next = wbyte[LIN_W-1:0];
      end
   end

   always @(posedge mclk) begin
      if (!rst_b) begin
         hs_stat_reg <= {HS_W{1'b0}};
         dvs_stat_reg <= {DVS_W{1'b0}};
         lin_stat_reg <= {LIN_W{1'b0}};
         hs_mask_reg <= `RFI_HS_MASK_RST;
         dvs_mask_reg <= `RFI_DVS_MASK_RST;
         lin_mask_reg <= `RFI_LIN_MASK_RST;
      end else begin
         hs_stat_reg <= hs_stat_next;
         dvs_stat_reg <= dvs_stat_next;
         lin_stat_reg <= lin_stat_next;
         hs_mask_reg <= hs_mask_next;
         dvs_mask_reg <= dvs_mask_next;
         lin_mask_reg <= lin_mask_next;
      end
   end

   // read mux; unused bits and unmapped words read zero
   always @* begin
      rd_byte = `RFI_SENSE_RST;
      case (idx)
         `RFI_IDX_HS_STAT: begin
            rd_byte = {5'h00, hs_stat_reg};
         end
         `RFI_IDX_HS_MASK: begin
            rd_byte = {5'h00, hs_mask_reg};
         end
         `RFI_IDX_HS_SENSE: begin
            rd_byte = {5'h00, hs_sense_reg};
         end
         `RFI_IDX_DVS_STAT: begin
            rd_byte = {6'h00, dvs_stat_reg};
         end
         `RFI_IDX_DVS_MASK: begin
            rd_byte = {6'h00, dvs_mask_reg};
         end
         `RFI_IDX_DVS_SENSE: begin
            rd_byte = {6'h00, dvs_sense_reg};
         end
         `RFI_IDX_LIN_STAT: begin
            rd_byte = {5'h00, lin_stat_reg};
         end
         `RFI_IDX_LIN_MASK: begin
            rd_byte = {5'h00, lin_mask_reg};
         end
         `RFI_IDX_LIN_SENSE: begin
            rd_byte = {5'h00, lin_sense_reg};
         end
         default: begin
            rd_byte = `RFI_SENSE_RST;
         end
      endcase
   end

   // registered answer, one cycle after the request is taken
   always @(posedge mclk) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req;
         if (rd_en) begin
            dat_reg <= {24'h000000, rd_byte};
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // any unmasked pending bit asserts the interrupt
   assign irq_pend = |(hs_stat_reg & ~hs_mask_reg)
                   | |(dvs_stat_reg & ~dvs_mask_reg)
                   | |(lin_stat_reg & ~lin_mask_reg);

   always @(posedge mclk) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_pend;
      end
   end

   // open-drain pin: drive low only while pending
   assign irq_o = irq_reg;
   assign irq_out_n = 1'b0;
   assign irq_out_n_oe = irq_reg;

endmodule // rfi_regulator_fault_irq_regs
`default_nettype wire

// file: testbench/rfi_irq_sva.sv
// port assertions for the regulator fault irq registers
`timescale 1ns/1ns
`default_nettype none
`include "rfi_regs.vh"
module rfi_irq_sva #(
   parameter SW_PERIOD_CYC = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [2:0] buck_hs_fault_in,
   input wire logic [1:0] buck_scaling_busy_in,
   input wire logic [2:0] linear_fault_in,
   input wire logic irq_o,
   input wire logic irq_out_n,
   input wire logic irq_out_n_oe
);
   // decode of the register being answered
   wire logic [5:0] ix = wb_adr_i[7:2];
   wire logic rd = wb_ack_o && !wb_we_i;
   wire logic dynamic_voltage_scaling = ix >= `RFI_IDX_DVS_STAT && ix <= `RFI_IDX_DVS_SENSE;
   wire logic mapped = (ix >= 6'h0B && ix <= 6'h10) || (ix >= 6'h18 && ix <= 6'h1A);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   pin_follow_a: assert property (irq_out_n_oe == irq_o && !irq_out_n)
      else $error("pin drive differs from irq");
   unused_bits_a: assert property (rd && mapped |-> !wb_dat_o[31:3] && !(dynamic_voltage_scaling && wb_dat_o[2]))
      else $error("unused bits read nonzero");
   unmapped_zero_a: assert property (rd && !mapped |-> wb_dat_o == 32'h0)
      else $error("unmapped read nonzero");
   irq_drop_a: assert property ($fell(irq_o) |-> $past(wb_ack_o))
      else $error("irq dropped without host access");
   reset_quiet_a: assert property ($rose(rst_b) |-> !irq_o ##1 !irq_o)
      else $error("irq raised out of reset");
endmodule // rfi_irq_sva
bind rfi_regulator_fault_irq_regs rfi_irq_sva #(.SW_PERIOD_CYC(SW_PERIOD_CYC)) rfi_irq_sva_i (
   .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .buck_hs_fault_in(buck_hs_fault_in),
   .buck_scaling_busy_in(buck_scaling_busy_in), .linear_fault_in(linear_fault_in),
   .irq_o(irq_o), .irq_out_n(irq_out_n), .irq_out_n_oe(irq_out_n_oe));
`default_nettype wire

// file: testbench/rfi_fault_src.sv
// fault detector model feeding the irq registers
`timescale 1ns/1ns
`default_nettype none
module rfi_fault_src (
   input wire logic mclk,
   input wire logic [2:0] hs_on,
   input wire logic [1:0] busy_on,
   input wire logic [2:0] lin_on,
   output logic [2:0] hs_out,
   output logic [1:0] busy_out,
   output logic [2:0] lin_out
);
   logic ph = 1'b0;
   // current limit trips only in half of each switching period
   always @(posedge mclk) begin
      ph <= ~ph;
      hs_out <= hs_on & {3{ph}};
      busy_out <= busy_on;
      lin_out <= lin_on;
   end
endmodule // rfi_fault_src
`default_nettype wire

// file: testbench/rfi_regulator_fault_irq_regs_tb.sv
// bench: host register traffic against fault stimulus
`timescale 1ns/1ns
`default_nettype none
`include "rfi_regs.vh"
module rfi_regulator_fault_irq_regs_tb;
   logic mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, dat, q;
   logic ack, irq, pin, oe;
   logic [2:0] hs_on = 3'h0, lin_on = 3'h0, hs_f, lin_f;
   logic [1:0] busy_on = 2'h0, busy_f;
   int n_mismatch = 0, checks_done = 0, n_cyc = 0;
   logic [5:0] ix_tab [10] = '{6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h18, 6'h19, 6'h1A, 6'h05};
   logic [7:0] rv_tab [10] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
   always #2 mclk = ~mclk;
   rfi_regulator_fault_irq_regs #(.SW_PERIOD_CYC(4)) rfi_regulator_fault_irq_regs_i (
      .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .buck_hs_fault_in(hs_f),
      .buck_scaling_busy_in(busy_f), .linear_fault_in(lin_f), .irq_o(irq), .irq_out_n(pin),
      .irq_out_n_oe(oe));
   rfi_fault_src rfi_fault_src_i (.mclk(mclk), .hs_on(hs_on), .busy_on(busy_on), .lin_on(lin_on),
      .hs_out(hs_f), .busy_out(busy_f), .lin_out(lin_f));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge mclk); while (ack !== 1'b1);
      q = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] ix, input logic [7:0] d);
      xfer(1'b1, ix, d);
   endtask
   task automatic rdc(input logic [5:0] ix, input logic [7:0] e);
      xfer(1'b0, ix, 8'h00);
      chk(q[7:0], e);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge mclk);
      chk({5'h0, pin, irq, oe}, {6'h0, e, e});
   endtask
   // hang guard
   always @(posedge mclk) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 5000) begin
         n_mismatch++;
         stop_test;
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 10; i++) rdc(ix_tab[i], rv_tab[i]);
      chk_irq(1'b0);
      wr(`RFI_IDX_HS_SENSE, 8'hFF);
      rdc(`RFI_IDX_HS_SENSE, 8'h00);
      wr(`RFI_IDX_HS_MASK, 8'hFF);
      rdc(`RFI_IDX_HS_MASK, 8'h07);
      wr(`RFI_IDX_DVS_MASK, 8'hFF);
      rdc(`RFI_IDX_DVS_MASK, 8'h03);
      sel <= 4'hE;
      wr(`RFI_IDX_DVS_MASK, 8'h00);
      sel <= 4'hF;
      rdc(`RFI_IDX_DVS_MASK, 8'h03);
      $display("test reset and access done");
      lin_on <= 3'h5;
      repeat (8) @(posedge mclk);
      rdc(`RFI_IDX_LIN_SENSE, 8'h05);
      chk_irq(1'b0);
      wr(`RFI_IDX_LIN_STAT, 8'h00);
      wr(`RFI_IDX_LIN_MASK, 8'h02);
      repeat (3) @(posedge mclk);
      chk_irq(1'b1);
      rdc(`RFI_IDX_LIN_STAT, 8'h05);
      rdc(`RFI_IDX_LIN_STAT, 8'h00);
      chk_irq(1'b0);
      lin_on <= 3'h0;
      $display("test linear faults done");
      hs_on <= 3'h4;
      repeat (16) @(posedge mclk);
      rdc(`RFI_IDX_HS_SENSE, 8'h04);
      rdc(`RFI_IDX_HS_SENSE, 8'h04);
      wr(`RFI_IDX_HS_MASK, 8'h03);
      repeat (3) @(posedge mclk);
      chk_irq(1'b1);
      wr(`RFI_IDX_HS_STAT, 8'h04);
      chk_irq(1'b0);
      rdc(`RFI_IDX_HS_STAT, 8'h00);
      hs_on <= 3'h0;
      repeat (16) @(posedge mclk);
      rdc(`RFI_IDX_HS_SENSE, 8'h00);
      $display("test high side done");
      wr(`RFI_IDX_DVS_MASK, 8'h00);
      busy_on <= 2'h3;
      repeat (6) @(posedge mclk);
      rdc(`RFI_IDX_DVS_SENSE, 8'h03);
      rdc(`RFI_IDX_DVS_STAT, 8'h00);
      busy_on <= 2'h0;
      repeat (6) @(posedge mclk);
      chk_irq(1'b1);
      rdc(`RFI_IDX_DVS_STAT, 8'h03);
      busy_on <= 2'h2;
      repeat (6) @(posedge mclk);
      busy_on <= 2'h0;
      repeat (6) @(posedge mclk);
      rdc(`RFI_IDX_DVS_SENSE, 8'h00);
      rdc(`RFI_IDX_DVS_STAT, 8'h02);
      chk_irq(1'b0);
      $display("test scaling done");
      stop_test;
   end
endmodule // rfi_regulator_fault_irq_regs_tb
`default_nettype wire
